// ---- rtl/msc_pkg.sv ----
// Package of constants and carrier types for the parameter-setting command decoder.
package msc_pkg;
    localparam logic [7:0] OPC_MODE_SELECT = 8'h15;
    localparam int PF_BIT = 4;
    localparam int SP_BIT = 0;
    localparam int CDB_LEN = 6;
    localparam int CDB_FLAGS_IDX = 1;
    localparam int CDB_LEN_IDX = 4;
    localparam int HDR_LEN = 4;
    localparam int HDR_BDL_IDX = 3;
    localparam logic [5:0] PG_CONFIG = 6'h25;
    localparam logic [5:0] PG_OFFLINE = 6'h30;
    localparam logic [5:0] PG_ABORT = 6'h31;
    localparam logic [5:0] PG_RESET = 6'h32;
    localparam logic [7:0] PLEN_CONFIG = 8'h14;
    localparam logic [7:0] PLEN_OFFLINE = 8'h03;
    localparam logic [7:0] PLEN_ABORT = 8'h00;
    localparam logic [7:0] PLEN_RESET = 8'h01;
    localparam int CFG_WIDTH_IDX = 2;
    localparam int CFG_WIDTH_BIT = 3;
    localparam int CFG_ID_IDX = 3;
    localparam int CFG_MODE_IDX = 8;
    localparam int CFG_MBH_IDX = 9;
    localparam int CFG_MBL_IDX = 10;
    localparam int OFF_OP_IDX = 2;
    localparam int OFF_SRC_IDX = 3;
    localparam int OFF_DST_IDX = 4;
    localparam int RST_CODE_IDX = 2;
    localparam int PAGE_BUF = 22;
    localparam logic [3:0] OPM_PASS1 = 4'h0;
    localparam logic [3:0] OPM_PASS2 = 4'h1;
    localparam logic [3:0] OPM_MIRROR = 4'h3;
    localparam logic [3:0] RST_ID = 4'h0;
    localparam logic [3:0] RST_OPMODE = 4'h0;

    // Controller configuration applied as one unit.
    typedef struct packed {
        logic wideBus;
        logic [3:0] busId;
        logic [3:0] opMode;
        logic [1:0] mirrorMode;
    } msc_cfg_t;

    // Offline operation request.
    typedef struct packed {
        logic [3:0] opCode;
        logic [1:0] srcMask;
        logic [1:0] dstMask;
    } msc_offline_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CDB = 5'b00010,
        ST_DATA = 5'b00100,
        ST_CHECK = 5'b01000,
        ST_DONE = 5'b10000
    } msc_state_t;
endpackage

// ---- rtl/msc_page_check.sv ----
// Page code and page length checker for one received parameter page.
`timescale 1ns/100ps
`default_nettype none
module msc_page_check (
    input wire logic [7:0] pageByte0,
    input wire logic [7:0] pageByte1,
    input wire logic [7:0] paramLen,
    input wire logic [7:0] opField,
    input wire logic [7:0] bdLen,
    output logic pageOk,
    output logic isConfig,
    output logic isOffline,
    output logic isAbort,
    output logic isReset
);
    import msc_pkg::*;

    logic [5:0] code;
    logic [7:0] plen;
    logic lenOk;
    logic opOk;

    // Only the four vendor pages are accepted, each with its own length and total.
    always_comb begin
        code = pageByte0[5:0];
        plen = pageByte1;
        isConfig = (code == PG_CONFIG);
        isOffline = (code == PG_OFFLINE);
        isAbort = (code == PG_ABORT);
        isReset = (code == PG_RESET);
        lenOk = (isConfig && plen == PLEN_CONFIG)
              || (isOffline && plen == PLEN_OFFLINE)
              || (isAbort && plen == PLEN_ABORT)
              || (isReset && plen == PLEN_RESET);
        // The total must cover header, code, length byte and page body exactly.
        lenOk = lenOk && (paramLen == 8'(HDR_LEN + 2) + plen);
        opOk = 1'b1;
        if (isConfig) begin
            opOk = (opField[7:4] == OPM_PASS1) || (opField[7:4] == OPM_PASS2)
                || (opField[7:4] == OPM_MIRROR);
        end else if (isOffline) begin
            opOk = (opField[3:0] == 4'h1) || (opField[3:0] == 4'h2) || (opField[3:0] == 4'h3)
                || (opField[3:0] == 4'h5) || (opField[3:0] == 4'h7);
        end else if (isReset) begin
            opOk = (opField == 8'h00) || (opField == 8'h01);
        end
        pageOk = lenOk && opOk && (bdLen == 8'h00);
    end
endmodule
`default_nettype wire

// ---- rtl/msc_mode_select.sv ----
// Parameter-setting command decoder: takes the command block and its parameter list.
`timescale 1ns/100ps
`default_nettype none
module msc_mode_select (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic byteValid,
    input wire logic cdbPhase,
    input wire logic [7:0] byteData,
    output logic cmdDone,
    output logic checkCond,
    output logic dataRequest,
    output logic saveRejected,
    output msc_pkg::msc_cfg_t config_q,
    output msc_pkg::msc_offline_t offlineReq,
    output logic offlineStart,
    output logic abortOps,
    output logic softReset,
    output logic hardReset
);
    import msc_pkg::*;

    typedef struct packed {
        msc_state_t state;
        logic [2:0] cdbIdx;
        logic [7:0] paramLen;
        logic [7:0] dataIdx;
        logic [7:0] bdLen;
        logic isModeSelect;
        logic [PAGE_BUF*8-1:0] page;
        logic cmdDone;
        logic checkCond;
        logic dataRequest;
        logic saveRejected;
        msc_cfg_t cfg;
        msc_offline_t offline;
        logic offlineStart;
        logic abortOps;
        logic softReset;
        logic hardReset;
    } msc_regs_t;

    msc_regs_t r;
    msc_regs_t next_r;
    logic pageOk;
    logic isConfig;
    logic isOffline;
    logic isAbort;
    logic isReset;
    logic [7:0] opField;

    function automatic logic [7:0] pgByte(input logic [PAGE_BUF*8-1:0] p, input int idx);
        pgByte = p[idx*8 +: 8];
    endfunction

    // Field that each page type needs range-checked.
    always_comb begin
        if (isConfig) begin
            opField = pgByte(r.page, CFG_MODE_IDX);
        end else if (isOffline) begin
            opField = pgByte(r.page, OFF_OP_IDX);
        end else begin
            opField = pgByte(r.page, RST_CODE_IDX);
        end
    end

    msc_page_check u_check (
        .pageByte0(pgByte(r.page, 0)),
        .pageByte1(pgByte(r.page, 1)),
        .paramLen(r.paramLen),
        .opField(opField),
        .bdLen(r.bdLen),
        .pageOk(pageOk),
        .isConfig(isConfig),
        .isOffline(isOffline),
        .isAbort(isAbort),
        .isReset(isReset)
    );

    // Sequencer: command block, then data-out bytes, then a single check step.
    always_comb begin
        next_r = r;
        next_r.cmdDone = 1'b0;
        next_r.offlineStart = 1'b0;
        next_r.abortOps = 1'b0;
        next_r.softReset = 1'b0;
        next_r.hardReset = 1'b0;
        case (r.state)
            ST_IDLE: begin
                if (byteValid && cdbPhase) begin
                    // The opcode picks this command; other opcodes still clear status and run the command block but open no data phase.
                    next_r.isModeSelect = (byteData == OPC_MODE_SELECT);
                    next_r.cdbIdx = 3'd1;
                    next_r.checkCond = 1'b0;
                    next_r.saveRejected = 1'b0;
                    next_r.state = ST_CDB;
                end
            end
            ST_CDB: begin
                if (byteValid && cdbPhase) begin
                    if (r.cdbIdx == 3'(CDB_FLAGS_IDX)) begin
                        // Save-pages cannot be honoured; flag it and never store.
                        next_r.saveRejected = byteData[SP_BIT];
                    end
                    if (r.cdbIdx == 3'(CDB_LEN_IDX)) begin
                        next_r.paramLen = byteData;
                    end
                    next_r.cdbIdx = r.cdbIdx + 3'd1;
                    if (r.cdbIdx == 3'(CDB_LEN - 1)) begin
                        next_r.dataIdx = 8'h00;
                        next_r.page = '0;
                        if (!r.isModeSelect) begin
                            next_r.state = ST_IDLE;
                        end else if (r.paramLen == 8'h00) begin
                            // Empty list sets nothing and ends the command cleanly.
                            next_r.cmdDone = 1'b1;
                            next_r.state = ST_IDLE;
                        end else begin
                            next_r.dataRequest = 1'b1;
                            next_r.state = ST_DATA;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (byteValid && !cdbPhase) begin
                    // Header first, then page bytes; extras past the buffer are dropped.
                    if (r.dataIdx == 8'(HDR_BDL_IDX)) begin
                        next_r.bdLen = byteData;
                    end else if (r.dataIdx >= 8'(HDR_LEN)
                            && r.dataIdx < 8'(HDR_LEN + PAGE_BUF)) begin
                        next_r.page[(int'(r.dataIdx) - HDR_LEN)*8 +: 8] = byteData;
                    end
                    next_r.dataIdx = r.dataIdx + 8'd1;
                    if (r.dataIdx + 8'd1 == r.paramLen) begin
                        next_r.dataRequest = 1'b0;
                        next_r.state = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                if (pageOk) begin
                    if (isConfig) begin
                        // All fields update in one edge so no mix is ever seen.
                        next_r.cfg.wideBus = r.page[CFG_WIDTH_IDX*8 + CFG_WIDTH_BIT];
                        next_r.cfg.busId = r.page[CFG_ID_IDX*8 + 4 +: 4];
                        next_r.cfg.opMode = r.page[CFG_MODE_IDX*8 + 4 +: 4];
                        next_r.cfg.mirrorMode = {r.page[CFG_MBH_IDX*8 + 7],
                            r.page[CFG_MBL_IDX*8 + 7]};
                    end else if (isOffline) begin
                        // Drive masks ride along with the operation code as one request.
                        next_r.offline.opCode = r.page[OFF_OP_IDX*8 +: 4];
                        next_r.offline.srcMask = r.page[OFF_SRC_IDX*8 +: 2];
                        next_r.offline.dstMask = r.page[OFF_DST_IDX*8 +: 2];
                        next_r.offlineStart = 1'b1;
                    end else if (isAbort) begin
                        next_r.abortOps = 1'b1;
                    end else begin
                        next_r.softReset = !r.page[RST_CODE_IDX*8];
                        next_r.hardReset = r.page[RST_CODE_IDX*8];
                    end
                end else begin
                    next_r.checkCond = 1'b1;
                end
                next_r.state = ST_DONE;
            end
            ST_DONE: begin
                next_r.cmdDone = 1'b1;
                next_r.state = ST_IDLE;
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase
    end

    // State register; synchronous reset to defined values.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.cfg.busId <= RST_ID;
            r.cfg.opMode <= RST_OPMODE;
        end else begin
            r <= next_r;
        end
    end

    assign cmdDone = r.cmdDone;
    assign checkCond = r.checkCond;
    assign dataRequest = r.dataRequest;
    assign saveRejected = r.saveRejected;
    assign config_q = r.cfg;
    assign offlineReq = r.offline;
    assign offlineStart = r.offlineStart;
    assign abortOps = r.abortOps;
    assign softReset = r.softReset;
    assign hardReset = r.hardReset;

    // A foreign opcode never opens a data phase, and a new command clears old status.
    AST_OPCODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_IDLE && byteValid && cdbPhase && byteData != OPC_MODE_SELECT)
        |=> ##5 !r.dataRequest) else $error("Other opcode opened data phase");
    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_IDLE && byteValid && cdbPhase) |=> !r.checkCond)
        else $error("Old check condition survived a new command");

    // Command block fields are captured from the byte that carries them.
    AST_SAVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CDB && byteValid && cdbPhase && r.cdbIdx == 3'(CDB_FLAGS_IDX))
        |=> r.saveRejected == $past(byteData[SP_BIT])) else $error("Save flag not taken");
    AST_PLEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CDB && byteValid && cdbPhase && r.cdbIdx == 3'(CDB_LEN_IDX))
        |=> r.paramLen == $past(byteData)) else $error("List length not taken");

    // Data requests stand only while list bytes are still owed.
    AST_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_DATA && byteValid && !cdbPhase && r.dataIdx + 8'd1 == r.paramLen)
        |=> r.state == ST_CHECK && !r.dataRequest) else $error("Byte count not honoured");
    AST_DREQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.dataRequest |-> r.state == ST_DATA) else $error("Data request outside data phase");
    AST_HDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_DATA && byteValid && !cdbPhase && r.dataIdx == 8'(HDR_BDL_IDX))
        |=> r.bdLen == $past(byteData)) else $error("Descriptor length not taken");

    // Refusals: each reason on its own raises the check condition.
    AST_BDLEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && r.bdLen != 8'h00) |=> r.checkCond) else $error("Descriptor len");
    AST_PAGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && !(isConfig || isOffline || isAbort || isReset))
        |=> r.checkCond) else $error("Unknown page accepted");
    AST_CFGLEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && isConfig && r.page[8 +: 8] != PLEN_CONFIG)
        |=> r.checkCond) else $error("Bad configuration length accepted");
    AST_REJECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && !pageOk) |=> $stable(r.cfg) && r.checkCond)
        else $error("Rejected page changed config");

    // Configuration changes only at the check step, all fields at once.
    AST_ATOMIC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state != ST_CHECK) |=> $stable(r.cfg)) else $error("Config changed outside check");
    AST_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && pageOk && isConfig)
        |=> r.cfg.wideBus == $past(r.page[CFG_WIDTH_IDX*8 + CFG_WIDTH_BIT])
        && r.cfg.busId == $past(r.page[CFG_ID_IDX*8+4 +: 4])) else $error("Width or id");
    AST_OPMODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && pageOk && isConfig)
        |=> r.cfg.opMode == $past(r.page[CFG_MODE_IDX*8+4 +: 4])) else $error("Mode field");
    AST_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK && pageOk && isConfig)
        |=> r.cfg.opMode != 4'h2 && r.cfg.mirrorMode == {$past(r.page[CFG_MBH_IDX*8+7]),
        $past(r.page[CFG_MBL_IDX*8+7])}) else $error("Mode decode");

    // Every command that reaches the check step completes with one done pulse.
    AST_DONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == ST_CHECK) |=> ##1 r.cmdDone) else $error("Check step did not complete");
    AST_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.cmdDone |=> !r.cmdDone) else $error("Done pulse too long");

    // Page actions fire only with the fields that justify them.
    AST_ABORT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.abortOps |-> ##1 r.cmdDone && !r.checkCond) else $error("Abort not completed");
    AST_ABORTLEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.abortOps |-> r.page[8 +: 8] == PLEN_ABORT) else $error("Abort with bad length");
    AST_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(r.softReset && r.hardReset)) else $error("Both resets at once");
    AST_SOFT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.softReset |-> r.page[RST_CODE_IDX*8 +: 8] == 8'h00) else $error("Soft reset code");
    AST_HARD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.hardReset |-> r.page[RST_CODE_IDX*8 +: 8] == 8'h01) else $error("Hard reset code");
    AST_OFFLINE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.offlineStart |-> r.offline.opCode inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h7})
        else $error("Illegal offline op");
    AST_OFFSRC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.offlineStart |-> r.offline.srcMask == r.page[OFF_SRC_IDX*8 +: 2]
        && r.offline.dstMask == r.page[OFF_DST_IDX*8 +: 2]) else $error("Drive masks");

    // Main scenarios that the bench is expected to reach.
    COV_CFG: cover property (@(posedge clk_sys) r.state == ST_CHECK && pageOk && isConfig);
    COV_BAD: cover property (@(posedge clk_sys) r.state == ST_CHECK && !pageOk);
    COV_ABORT: cover property (@(posedge clk_sys) r.abortOps);
    COV_HARD: cover property (@(posedge clk_sys) r.hardReset);
    COV_OFF: cover property (@(posedge clk_sys) r.offlineStart);
endmodule
`default_nettype wire

// ---- verification/msc_host_model.sv ----
// Behavioural initiator that feeds command and parameter bytes to the decoder.
`timescale 1ns/100ps
`default_nettype none
module msc_host_model (
    input wire logic clk_sys,
    output logic byteValid,
    output logic cdbPhase,
    output logic [7:0] byteData
);
    import msc_pkg::*;
    // Lines start quiet: valid and phase low, data line at zero.
    initial begin
        byteValid = 1'b0;
        cdbPhase = 1'b0;
        byteData = 8'h00;
    end
    // Offers one byte per cycle, changing lines only at the falling edge.
    task automatic put(input logic ph, input logic [7:0] b);
        @(negedge clk_sys);
        byteValid = 1'b1;
        cdbPhase = ph;
        byteData = b;
    endtask
    // Six command bytes, then the list; the count byte always equals the list size.
    task automatic send(input logic [7:0] opc, input logic sp, input logic [7:0] d[$]);
        logic [7:0] f;
        f = 8'h00;
        f[PF_BIT] = 1'b1;
        f[SP_BIT] = sp;
        put(1'b1, opc);
        put(1'b1, f);
        put(1'b1, 8'h00);
        put(1'b1, 8'h00);
        put(1'b1, 8'(d.size()));
        put(1'b1, 8'h00);
        foreach (d[i]) put(1'b0, d[i]);
        @(negedge clk_sys);
        byteValid = 1'b0;
        byteData = ~byteData; // Released line shows the inverse of the last byte.
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking testbench for the parameter-setting command decoder.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import msc_pkg::*;
    logic clk_sys, rst_n, byteValid, cdbPhase, cmdDone, checkCond, dataRequest, saveRejected;
    logic [7:0] byteData;
    msc_cfg_t config_q, expCfg;
    msc_offline_t offlineReq;
    logic offlineStart, abortOps, softReset, hardReset;
    logic seenDone, seenOff, seenAbort, seenSoft, seenHard, good;
    logic [7:0] pl[$];
    logic [3:0] ops[8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h0, 4'h4, 4'h6};
    logic [3:0] okModes[3] = '{OPM_PASS1, OPM_PASS2, OPM_MIRROR};
    logic [1:0] src, dst;
    int failures, comparisons, seed;

    msc_mode_select dut (.clk_sys(clk_sys), .rst_n(rst_n), .byteValid(byteValid),
        .cdbPhase(cdbPhase), .byteData(byteData), .cmdDone(cmdDone), .checkCond(checkCond),
        .dataRequest(dataRequest), .saveRejected(saveRejected), .config_q(config_q),
        .offlineReq(offlineReq), .offlineStart(offlineStart), .abortOps(abortOps),
        .softReset(softReset), .hardReset(hardReset));
    msc_host_model host (.clk_sys(clk_sys), .byteValid(byteValid), .cdbPhase(cdbPhase),
        .byteData(byteData));

    // Free-running 100 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // One-cycle pulses are latched so a check after completion cannot miss them.
    always @(posedge clk_sys) begin
        if (cmdDone) seenDone <= 1'b1;
        if (offlineStart) seenOff <= 1'b1;
        if (abortOps) seenAbort <= 1'b1;
        if (softReset) seenSoft <= 1'b1;
        if (hardReset) seenHard <= 1'b1;
    end

    task automatic end_sim;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_cfg(input msc_cfg_t got, input msc_cfg_t exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: config %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_off(input msc_offline_t got, input msc_offline_t exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: offline %h expected %h", $time, got, exp);
        end
    endtask

    // Header with a chosen descriptor length; reserved bytes are zero.
    task automatic hdr(input logic [7:0] bdl);
        pl = '{8'h00, 8'h00, 8'h00, bdl};
    endtask

    // Runs one command; the bounded wait starts after the whole list is sent and covers the check and done steps with margin.
    task automatic run(input logic [7:0] opc, input logic sp, input logic expDone);
        seenDone = 1'b0;
        seenOff = 1'b0;
        seenAbort = 1'b0;
        seenSoft = 1'b0;
        seenHard = 1'b0;
        host.send(opc, sp, pl);
        for (int i = 0; i < 40 && !seenDone; i++) @(negedge clk_sys);
        check_bit(seenDone, expDone);
        check_bit(dataRequest, 1'b0);
    endtask

    // Configuration page with random junk in the reserved bits of bytes 0, 2, 3 and 8 to 10; bytes 4 to 7 and 11 to 21 are zero.
    task automatic cfg_page(input logic [5:0] code, input logic [7:0] plen, input logic w,
        input logic [3:0] id, input logic [3:0] mode, input logic mh, input logic ml,
        input logic [7:0] bdl);
        logic [7:0] r;
        r = 8'($random(seed));
        hdr(bdl);
        pl.push_back({r[7:6], code});
        pl.push_back(plen);
        pl.push_back({r[3:0], w, r[2:0]});
        pl.push_back({id, r[3:0]});
        repeat (4) pl.push_back(8'h00);
        pl.push_back({mode, r[7:4]});
        pl.push_back({mh, r[6:0]});
        pl.push_back({ml, r[7:1]});
        repeat (11) pl.push_back(8'h00);
    endtask

    // A config command with random fields; a bad mode must leave the old set intact.
    task automatic try_cfg(input logic [3:0] mode, input logic sp);
        logic w, mh, ml;
        logic [3:0] id;
        logic ok;
        {w, mh, ml, id} = 7'($random(seed));
        ok = (mode == OPM_PASS1) || (mode == OPM_PASS2) || (mode == OPM_MIRROR);
        cfg_page(PG_CONFIG, PLEN_CONFIG, w, id, mode, mh, ml, 8'h00);
        run(OPC_MODE_SELECT, sp, 1'b1);
        if (ok) expCfg = '{wideBus: w, busId: id, opMode: mode, mirrorMode: {mh, ml}};
        check_bit(checkCond, !ok);
        check_cfg(config_q, expCfg);
        check_bit(saveRejected, sp);
    endtask

    // Main sequence: configuration, refusals, offline, abort and reset pages.
    initial begin
        rst_n = 1'b0;
        seed = 32'ha141b2c6;
        failures = 0;
        comparisons = 0;
        expCfg = '0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        check_cfg(config_q, expCfg);
        repeat (6) try_cfg(okModes[$unsigned($random(seed)) % 3], 1'b0);
        try_cfg(4'h2, 1'b0);
        try_cfg(4'hF, 1'b0);
        try_cfg(OPM_MIRROR, 1'b1);
        cfg_page(6'h26, PLEN_CONFIG, 1'b1, 4'hA, OPM_PASS2, 1'b1, 1'b0, 8'h00);
        run(OPC_MODE_SELECT, 1'b0, 1'b1);
        check_bit(checkCond, 1'b1);
        cfg_page(PG_CONFIG, 8'h13, 1'b1, 4'hA, OPM_PASS2, 1'b1, 1'b0, 8'h00);
        run(OPC_MODE_SELECT, 1'b0, 1'b1);
        check_bit(checkCond, 1'b1);
        cfg_page(PG_CONFIG, PLEN_CONFIG, 1'b1, 4'hA, OPM_PASS2, 1'b1, 1'b0, 8'h08);
        run(OPC_MODE_SELECT, 1'b0, 1'b1);
        check_bit(checkCond, 1'b1);
        check_cfg(config_q, expCfg);
        cfg_page(PG_CONFIG, PLEN_CONFIG, 1'b1, 4'hA, OPM_PASS2, 1'b1, 1'b0, 8'h00);
        run(8'h55, 1'b0, 1'b0);
        check_cfg(config_q, expCfg);
        foreach (ops[i]) begin
            {src, dst} = 4'($random(seed));
            hdr(8'h00);
            pl.push_back({2'b00, PG_OFFLINE});
            pl.push_back(PLEN_OFFLINE);
            pl.push_back({4'h0, ops[i]});
            pl.push_back({6'h00, src});
            pl.push_back({6'h00, dst});
            good = ops[i] inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
            run(OPC_MODE_SELECT, 1'b0, 1'b1);
            check_bit(checkCond, !good);
            check_bit(seenOff, good);
            if (good) check_off(offlineReq, {ops[i], src, dst});
        end
        hdr(8'h00);
        pl.push_back({2'b00, PG_ABORT});
        pl.push_back(PLEN_ABORT);
        run(OPC_MODE_SELECT, 1'b0, 1'b1);
        check_bit(seenAbort, 1'b1);
        // An empty list ends the command at once with nothing applied.
        pl.delete();
        run(OPC_MODE_SELECT, 1'b0, 1'b1);
        check_bit(checkCond, 1'b0);
        for (int c = 0; c < 3; c++) begin
            hdr(8'h00);
            pl.push_back({2'b00, PG_RESET});
            pl.push_back(PLEN_RESET);
            pl.push_back(8'(c));
            run(OPC_MODE_SELECT, 1'b0, 1'b1);
            check_bit(seenSoft, c == 0);
            check_bit(seenHard, c == 1);
            check_bit(checkCond, c > 1);
        end
        check_cfg(config_q, expCfg);
        end_sim;
    end

    // Watchdog well beyond the expected run of about seven microseconds.
    initial begin
        #200us;
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule
`default_nettype wire
